/* File: tos_sched.sv */
// timed output scheduler, two outputs, time-stamped entry queue
// assumes image port and commit come from backplane logic on clk;
// the variant strap is an asynchronous pin
// Contract
// - input image is four bytes, fixed
// - output image 20 or 60 bytes by variant
// - length parameters ignore writes
// - short variant: five four-byte entries
// - control byte: q0 b7, q1 b6, en b5/b4
// - written entries appended to queue
// - status bytes reported in input image
// - output follows state only when enabled
// - due entry applied, then removed
// - entry time is ticker value
`timescale 1ns/1ps
`default_nettype none
module tos_sched
  import tos_pkg::*;
(
  input wire logic clk, // 10 MHz
  input wire logic resetn, // sync reset, low
  input wire logic variant_long_pin, // strap, 1 = 60-byte image
  input wire logic oimg_wr, // output image byte write
  input wire logic [5:0] oimg_addr, // output image byte address
  input wire logic [7:0] oimg_wdata, // output image byte
  input wire logic oimg_commit, // image complete, queue it
  input wire logic [1:0] iimg_addr, // input image byte address
  output logic [7:0] iimg_rdata_r, // input image byte, next cycle
  input wire logic par_addr, // 0 input length, 1 output length
  input wire logic par_wr, // parameter write, dropped
  input wire logic [7:0] par_wdata, // parameter data, dropped
  output logic [7:0] par_rdata_r, // parameter byte, next cycle
  output logic [1:0] do_out_r, // digital outputs
  output logic [1:0] do_en_r, // output enables
  output logic busy_r // copying image into queue
);
  logic [7:0] oimg_r [0:59];
  logic var_s1_r, var_s2_r, var_long_r, var_long_nxt;
  logic cap_done_r, cap_done_nxt;
  tos_state_t state_r, state_nxt;
  logic [3:0] idx_r, idx_nxt;
  logic [7:0] last_seq_r, last_seq_nxt;
  logic lastseen_r, lastseen_nxt;
  logic active_r, active_nxt;
  logic ovf_r, ovf_nxt;
  logic [1:0] do_out_nxt, do_en_nxt;
  logic [7:0] iimg_nxt, par_nxt;
  logic busy_nxt;
  logic tick;
  logic [15:0] us_cnt;
  logic [31:0] head;
  logic [31:0] push_word;
  logic [5:0] q_cnt;
  logic q_empty, q_full;
  logic push, fire;
  logic [5:0] base;
  logic [3:0] n_ent;
  logic [7:0] out_len;
  logic [7:0] seq_cur;
  logic [7:0] ctl_head;
  logic par_wr_seen;

  tos_ticker u_tick
  (
    .clk(clk),
    .resetn(resetn),
    .tick_r(tick),
    .cnt_r(us_cnt)
  );

  tos_fifo u_fifo
  (
    .clk(clk),
    .resetn(resetn),
    .push(push),
    .din(push_word),
    .pop(fire),
    .dout(head),
    .count(q_cnt),
    .empty(q_empty),
    .full(q_full)
  );

  // output image store, written byte by byte by the backplane
  always_ff @(posedge clk)
  begin
    if (oimg_wr && oimg_addr < out_len[5:0])
      oimg_r[oimg_addr] <= oimg_wdata;
  end

  // strap synchroniser, no reset: the strap is already
  // through both flops by the time reset lifts
  always_ff @(posedge clk)
  begin
    var_s1_r <= variant_long_pin;
    var_s2_r <= var_s1_r;
  end

  // variant caught once after reset, then frozen
  always_comb
  begin
    cap_done_nxt = 1'b1;
    var_long_nxt = cap_done_r ? var_long_r : var_s2_r;
  end

  // entry count and image length follow the variant
  assign n_ent = var_long_r ? ENT_LONG : ENT_SHORT;
  assign out_len = var_long_r ? OUT_LEN_LONG : OUT_LEN_SHORT;

  // byte address of the entry being copied
  assign base = {idx_r, 2'b00};
  assign seq_cur = oimg_r[base | {4'h0, OFS_SEQ}];
  // time field is a ticker value, high byte at +3
  assign push_word = {oimg_r[base | {4'h0, OFS_CTL}], seq_cur,
                      oimg_r[base | {4'h0, OFS_THI}],
                      oimg_r[base | {4'h0, OFS_TLO}]};
  // copy one entry per cycle behind what is queued
  assign push = (state_r == TOS_COPY) & ~q_full;
  // due when the fresh ticker value equals the time
  assign fire = tick & ~q_empty & (us_cnt == head[15:0]);
  assign ctl_head = head[31:24];

  // copy walker over the entries of a committed image
  always_comb
  begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    last_seq_nxt = last_seq_r;
    lastseen_nxt = lastseen_r;
    ovf_nxt = ovf_r;
    busy_nxt = 1'b0;
    case (state_r)
      TOS_IDLE:
      begin
        if (oimg_commit)
        begin
          state_nxt = TOS_COPY;
          idx_nxt = 4'h0;
          lastseen_nxt = 1'b0;
          busy_nxt = 1'b1;
        end
      end
      TOS_COPY:
      begin
        busy_nxt = 1'b1;
        // a full queue drops the entry and flags it
        if (q_full)
          ovf_nxt = 1'b1;
        else
          last_seq_nxt = seq_cur;
        // the host's last marker ends the copy early
        if (seq_cur[SEQ_LAST])
          lastseen_nxt = 1'b1;
        if (seq_cur[SEQ_LAST] || idx_r == n_ent - 4'h1)
        begin
          state_nxt = TOS_IDLE;
          busy_nxt = 1'b0;
        end
        else
          idx_nxt = idx_r + 4'h1;
      end
      default:
      begin
        state_nxt = TOS_IDLE;
        idx_nxt = 4'h0;
      end
    endcase
  end

  // output stage
  always_comb
  begin
    do_out_nxt = do_out_r;
    do_en_nxt = do_en_r;
    active_nxt = active_r | fire;
    if (fire)
    begin
      // apply states and enables of the due entry
      do_en_nxt[0] = ctl_head[CTL_EN0];
      do_en_nxt[1] = ctl_head[CTL_EN1];
      do_out_nxt[0] = ctl_head[CTL_EN0] & ctl_head[CTL_Q0];
      do_out_nxt[1] = ctl_head[CTL_EN1] & ctl_head[CTL_Q1];
    end
  end

  // input image and parameter read data
  always_comb
  begin
    case (iimg_addr)
      IN_LAST: iimg_nxt = last_seq_r;
      IN_NEXT: iimg_nxt = q_empty ? 8'h00 : {2'b11, head[21:16]};
      IN_STS: iimg_nxt = {lastseen_r, 5'h00, active_r, ovf_r};
      IN_CNT: iimg_nxt = {2'b00, q_cnt};
      default: iimg_nxt = 8'h00;
    endcase
    // lengths are constants, writes have no effect
    par_nxt = par_addr ? out_len : IN_LEN;
  end

  // a write attempt with data differing from the record is seen and deliberately discarded
  assign par_wr_seen = par_wr & (par_wdata != par_nxt);

  // state registers, one sync reset; image store and strap synchroniser flops are not reset
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      cap_done_r <= 1'b0;
      var_long_r <= 1'b0;
      state_r <= TOS_IDLE;
      idx_r <= 4'h0;
      last_seq_r <= 8'h00;
      lastseen_r <= 1'b0;
      active_r <= 1'b0;
      ovf_r <= 1'b0;
      busy_r <= 1'b0;
      do_out_r <= 2'b00;
      do_en_r <= 2'b00;
      iimg_rdata_r <= 8'h00;
      par_rdata_r <= 8'h00;
    end
    else
    begin
      cap_done_r <= cap_done_nxt;
      var_long_r <= var_long_nxt;
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      last_seq_r <= last_seq_nxt;
      lastseen_r <= lastseen_nxt;
      active_r <= active_nxt;
      ovf_r <= ovf_nxt;
      busy_r <= busy_nxt;
      do_out_r <= do_out_nxt;
      do_en_r <= do_en_nxt;
      iimg_rdata_r <= iimg_nxt;
      par_rdata_r <= par_nxt;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // a due entry that leaves output 0 disabled
  sequence fire_s;
    fire ##0 (ctl_head[CTL_EN0] == 1'b0);
  endsequence
  // a commit taken while idle
  sequence copy_s;
    (state_r == TOS_IDLE) && oimg_commit;
  endsequence

  in_len_a: assert property (par_addr == 1'b0 |=> par_rdata_r == 8'h04)
    else $error("input length not four");
  out_len_a: assert property (par_addr && cap_done_r |=> par_rdata_r == 8'h14 || par_rdata_r == 8'h3C)
    else $error("output length not 20 or 60");
  par_fixed_a: assert property (par_wr_seen && par_addr |=> par_rdata_r == $past(out_len))
    else $error("length changed by write");
  copy_len_a: assert property ((copy_s and !var_long_r) |-> ##[2:6] state_r == TOS_IDLE)
    else $error("short copy runs past five entries");
  en_gate_a: assert property (fire_s |=> do_out_r[0] == 1'b0 && do_en_r[0] == 1'b0)
    else $error("disabled output driven");
  apply_a: assert property (fire |=> do_en_r == {$past(ctl_head[CTL_EN1]), $past(ctl_head[CTL_EN0])})
    else $error("enables not taken from entry");
  remove_a: assert property (fire && !push |=> q_cnt == $past(q_cnt) - 6'h01)
    else $error("fired entry not removed");
  hold_a: assert property (!fire |=> $stable(do_out_r) && $stable(do_en_r))
    else $error("outputs changed off schedule");
  append_a: assert property (push && !fire |=> q_cnt == $past(q_cnt) + 6'h01)
    else $error("entry not appended");
  count_a: assert property (iimg_addr == IN_CNT |=> iimg_rdata_r == {2'b00, $past(q_cnt)})
    else $error("queued count misreported");
  tick_gap_a: assert property (tick |=> !tick [*8])
    else $error("ticker faster than one microsecond");

  // further state checks
  var_frozen_a: assert property (cap_done_r |=> $stable(var_long_r))
    else $error("variant changed after capture");
  busy_state_a: assert property (busy_r == (state_r == TOS_COPY))
    else $error("busy flag out of step with copy");
  idle_quiet_a: assert property ((state_r == TOS_IDLE) && !oimg_commit |=> !busy_r)
    else $error("busy without commit");
  drop_full_a: assert property ((state_r == TOS_COPY) && q_full |=> ovf_r)
    else $error("dropped entry not flagged");
  marker_stop_a: assert property ((state_r == TOS_COPY) && seq_cur[SEQ_LAST] |=> state_r == TOS_IDLE)
    else $error("copy ran past last marker");
  ovf_sticky_a: assert property (ovf_r |=> ovf_r)
    else $error("overflow flag lost");
  active_set_a: assert property (fire |=> active_r)
    else $error("fired state not reported");
  next_empty_a: assert property ((iimg_addr == IN_NEXT) && q_empty |=> iimg_rdata_r == 8'h00)
    else $error("next sequence not zero when empty");
  fire_once_a: assert property (fire |=> !fire)
    else $error("entry fired twice in one tick");
  tick_move_a: assert property (tick |-> us_cnt != $past(us_cnt))
    else $error("tick without ticker step");
endmodule
`default_nettype wire

/* File: tos_pkg.sv */
// constants for the timed output scheduler
// assumes one 10 MHz clock shared with the backplane image logic
package tos_pkg;
  // ticker period and clock period, in ns
  localparam int US_NS = 1000;
  localparam int CLK_NS = 100;
  localparam int US_CYC = (US_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] US_LAST = 4'(US_CYC - 1);
  // parameter record values
  localparam logic [7:0] IN_LEN = 8'h04;
  localparam logic [7:0] OUT_LEN_SHORT = 8'h14;
  localparam logic [7:0] OUT_LEN_LONG = 8'h3C;
  localparam logic [3:0] ENT_SHORT = 4'h5;
  localparam logic [3:0] ENT_LONG = 4'hF;
  // byte offsets inside one entry
  localparam logic [1:0] OFS_CTL = 2'h0;
  localparam logic [1:0] OFS_SEQ = 2'h1;
  localparam logic [1:0] OFS_TLO = 2'h2;
  localparam logic [1:0] OFS_THI = 2'h3;
  // control byte and sequence number fields
  localparam int CTL_Q0 = 7;
  localparam int CTL_Q1 = 6;
  localparam int CTL_EN0 = 5;
  localparam int CTL_EN1 = 4;
  localparam int SEQ_LAST = 6;
  // input image byte offsets
  localparam logic [1:0] IN_LAST = 2'h0;
  localparam logic [1:0] IN_NEXT = 2'h1;
  localparam logic [1:0] IN_STS = 2'h2;
  localparam logic [1:0] IN_CNT = 2'h3;
  // queue state status bits
  localparam int STS_LASTSEEN = 7;
  localparam int STS_ACTIVE = 1;
  localparam int STS_OVF = 0;
  // queue size
  localparam int FIFO_AW = 5;
  localparam logic [5:0] FIFO_DEPTH = 6'h20;
  typedef enum logic [1:0] {TOS_IDLE = 2'b00, TOS_COPY = 2'b01} tos_state_t;
endpackage

/* File: tos_ticker.sv */
// free-running microsecond ticker
// assumes clk at the rate given by CLK_NS
`timescale 1ns/1ps
`default_nettype none
module tos_ticker
  import tos_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic resetn, // sync reset, low
  output logic tick_r, // one cycle, cnt_r just moved
  output logic [15:0] cnt_r // microsecond count
);
  logic [3:0] div_r;
  logic [3:0] div_nxt;
  logic tick_nxt;
  logic [15:0] cnt_nxt;

  // divider to 1 us, counter wraps 65535 to 0
  always_comb
  begin
    tick_nxt = (div_r == US_LAST);
    div_nxt = tick_nxt ? 4'h0 : div_r + 4'h1;
    cnt_nxt = tick_nxt ? cnt_r + 16'h0001 : cnt_r;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      div_r <= 4'h0;
      tick_r <= 1'b0;
      cnt_r <= 16'h0000;
    end
    else
    begin
      div_r <= div_nxt;
      tick_r <= tick_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule
`default_nettype wire

/* File: tos_fifo.sv */
// entry queue: 32 words, push and pop in one cycle allowed
// assumes the caller never pushes when full without popping
`timescale 1ns/1ps
`default_nettype none
module tos_fifo
  import tos_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic resetn, // sync reset, low
  input wire logic push, // append din
  input wire logic [31:0] din, // entry word
  input wire logic pop, // drop head
  output logic [31:0] dout, // head entry
  output logic [5:0] count, // entries held
  output logic empty, // nothing queued
  output logic full // no room
);
  logic [31:0] mem [0:31];
  logic [FIFO_AW-1:0] rd_r, rd_nxt, wr_r, wr_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic do_push, do_pop;

  // pointer and fill bookkeeping
  always_comb
  begin
    do_pop = pop & (cnt_r != 6'h00);
    do_push = push & ((cnt_r != FIFO_DEPTH) | do_pop);
    rd_nxt = do_pop ? rd_r + 5'h01 : rd_r;
    wr_nxt = do_push ? wr_r + 5'h01 : wr_r;
    cnt_nxt = cnt_r + {5'h00, do_push} - {5'h00, do_pop};
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rd_r <= 5'h00;
      wr_r <= 5'h00;
      cnt_r <= 6'h00;
    end
    else
    begin
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage has no reset, it is only read behind the count
  always_ff @(posedge clk)
  begin
    if (do_push)
      mem[wr_r] <= din;
  end

  assign dout = mem[rd_r];
  assign count = cnt_r;
  assign empty = (cnt_r == 6'h00);
  assign full = (cnt_r == FIFO_DEPTH);

  fill_bound_a: assert property (@(posedge clk) disable iff (!resetn) cnt_r <= FIFO_DEPTH)
    else $error("queue count beyond depth");
endmodule
`default_nettype wire

/* File: tos_host.sv */
// host model: fills the output image byte by byte and commits it
// assumes the bench calls its tasks from a process synced to clk
`timescale 1ns/1ps
`default_nettype none
module tos_host
  import tos_pkg::*;
(
  input wire logic clk, // system clock
  output logic wr, // image byte write
  output logic [5:0] addr, // image byte address
  output logic [7:0] wdata, // image byte
  output logic commit // queue request
);
  // idle bus at time zero
  initial
  begin
    wr = 1'b0;
    addr = 6'h00;
    wdata = 8'h00;
    commit = 1'b0;
  end
  // one byte, released bus shows inverted junk, not the old value
  task automatic put(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    #5;
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(posedge clk);
    #5;
    wr = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask
  task automatic entry(input logic [3:0] n, input logic [7:0] c, input logic [7:0] s, input logic [15:0] t);
    put({n, OFS_CTL}, c);
    put({n, OFS_SEQ}, s);
    put({n, OFS_TLO}, t[7:0]);
    put({n, OFS_THI}, t[15:8]);
  endtask
  // one-cycle commit pulse
  task automatic go();
    @(posedge clk);
    #5;
    commit = 1'b1;
    @(posedge clk);
    #5;
    commit = 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: tos_sched_test.sv */
// bench for the scheduler: length records, queueing, timed firing
// assumes a 10 MHz clock; the strap is set per run
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) \
  begin \
    n_checks++; \
    if ((a) !== (e)) \
    begin \
      mismatches++; \
      $display("[ERR] %s exp %h got %h", nm, e, a); \
    end \
  end
module tos_sched_test;
  import tos_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic var_long = 1'b0;
  logic [1:0] iimg_addr = 2'h0;
  logic par_addr = 1'b0;
  logic par_wr = 1'b0;
  logic [7:0] par_wdata = 8'h00;
  logic wr, commit;
  logic [5:0] addr;
  logic [7:0] wdata, iimg_rdata_r, par_rdata_r;
  logic [1:0] do_out_r, do_en_r;
  logic busy_r;
  int mismatches = 0;
  int n_checks = 0;
  int cyc = 0;
  int t;
  logic [1:0] exp_o [3] = '{2'b01, 2'b00, 2'b10};
  logic [1:0] exp_e [3] = '{2'b11, 2'b00, 2'b11};
  int exp_t [3] = '{40, 60, 80};

  tos_host tos_host_inst (.clk(clk), .wr(wr), .addr(addr), .wdata(wdata), .commit(commit));
  tos_sched tos_sched_inst (.clk(clk), .resetn(resetn), .variant_long_pin(var_long), .oimg_wr(wr),
    .oimg_addr(addr), .oimg_wdata(wdata), .oimg_commit(commit), .iimg_addr(iimg_addr),
    .iimg_rdata_r(iimg_rdata_r), .par_addr(par_addr), .par_wr(par_wr), .par_wdata(par_wdata),
    .par_rdata_r(par_rdata_r), .do_out_r(do_out_r), .do_en_r(do_en_r), .busy_r(busy_r));

  // 100 ns clock
  initial
  begin
    forever #50 clk = ~clk;
  end
  // cycles since release, and a hang limit well past the last entry
  always @(posedge clk)
  begin
    cyc <= resetn ? cyc + 1 : 0;
    if (cyc >= 20000)
    begin
      mismatches++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // read a status byte (p=0) or a length record (p=1), one cycle later
  task automatic rd(input logic p, input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    #5;
    if (p)
      par_addr = a[0];
    else
      iimg_addr = a;
    @(posedge clk);
    #5;
    d = p ? par_rdata_r : iimg_rdata_r;
  endtask
  // wait for an output change, bounded
  task automatic wait_chg(output int tc);
    logic [3:0] old;
    int k;
    old = {do_en_r, do_out_r};
    k = 0;
    while ({do_en_r, do_out_r} === old && k < 1500)
    begin
      @(posedge clk);
      #5;
      k++;
    end
    tc = cyc;
  endtask

  // main sequence
  initial
  begin
    logic [7:0] d;
    repeat (6) @(posedge clk);
    #5;
    resetn = 1'b1;
    repeat (4) @(posedge clk);
    rd(1'b1, 2'h0, d);
    `CHK("in length", 8'h04, d)
    rd(1'b1, 2'h1, d);
    `CHK("out length", 8'h14, d)
    @(posedge clk);
    #5;
    par_wr = 1'b1;
    par_wdata = 8'hFF;
    @(posedge clk);
    #5;
    par_addr = 1'b0;
    @(posedge clk);
    #5;
    par_wr = 1'b0;
    rd(1'b1, 2'h0, d);
    `CHK("in length kept", 8'h04, d)
    rd(1'b1, 2'h1, d);
    `CHK("out length kept", 8'h14, d)
    rd(1'b0, IN_CNT, d);
    `CHK("empty count", 8'h00, d)
    $display("length records done");
    tos_host_inst.entry(4'h0, 8'hB0, 8'h01, 16'd40);
    tos_host_inst.entry(4'h1, 8'h40, 8'h02, 16'd60);
    tos_host_inst.entry(4'h2, 8'h70, 8'h43, 16'd80);
    tos_host_inst.entry(4'h3, 8'hF0, 8'h04, 16'd90);
    tos_host_inst.go();
    `CHK("busy", 1'b1, busy_r)
    repeat (3) @(posedge clk);
    #5;
    `CHK("busy end", 1'b0, busy_r)
    rd(1'b0, IN_CNT, d);
    `CHK("count", 8'h03, d)
    rd(1'b0, IN_LAST, d);
    `CHK("last seq", 8'h43, d)
    rd(1'b0, IN_NEXT, d);
    `CHK("next seq", 8'hC1, d)
    rd(1'b0, IN_STS, d);
    `CHK("queue state", 8'h80, d)
    $display("queueing done");
    for (int i = 0; i < 3; i++)
    begin
      wait_chg(t);
      `CHK("fire time", 1'b1, (t >= exp_t[i] * 10 - 5 && t <= exp_t[i] * 10 + 20))
      `CHK("outputs", exp_o[i], do_out_r)
      `CHK("enables", exp_e[i], do_en_r)
      rd(1'b0, IN_CNT, d);
      `CHK("count left", 8'(2 - i), d)
    end
    rd(1'b0, IN_STS, d);
    `CHK("fired state", 8'h82, d)
    rd(1'b0, IN_NEXT, d);
    `CHK("next empty", 8'h00, d)
    $display("firing done");
    // second run: long strap held through a mid-run reset
    @(posedge clk);
    #5;
    resetn = 1'b0;
    var_long = 1'b1;
    repeat (3) @(posedge clk);
    #5;
    resetn = 1'b1;
    repeat (3) @(posedge clk);
    #5;
    `CHK("out reset", 2'b00, do_out_r)
    `CHK("en reset", 2'b00, do_en_r)
    rd(1'b1, 2'h1, d);
    `CHK("long length", 8'h3C, d)
    rd(1'b1, 2'h0, d);
    `CHK("in length long", 8'h04, d)
    // fifteen entries, no marker, times far off
    for (int n = 0; n < 15; n++)
      tos_host_inst.entry(4'(n), 8'h30, 8'(n + 1), 16'hF000);
    // three copies overrun the 32-word queue
    for (int c = 0; c < 3; c++)
    begin
      tos_host_inst.go();
      repeat (15) @(posedge clk);
      #5;
      `CHK("busy long", 1'b0, busy_r)
      rd(1'b0, IN_CNT, d);
      `CHK("count long", 8'((c + 1) * 15 > 32 ? 32 : (c + 1) * 15), d)
    end
    rd(1'b0, IN_STS, d);
    `CHK("overflow state", 8'h01, d)
    rd(1'b0, IN_LAST, d);
    `CHK("last pushed", 8'h02, d)
    $display("long variant done");
    close_out();
  end
endmodule
`default_nettype wire
